/* File: verification/testbench.sv */
// Testbench of the trigger and store control block
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // Signals
   logic        clk_sys_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [7:0]  paddr_in = 0;
   logic [31:0] pwdata_in = 0, prdata_out, conv_data_in, rv;
   logic        pready_out, pslverr_out, conv_start_out, conv_done_in, rerr;
   logic        dashes_out, blank_out, buf_full_out;
   logic [4:0]  stim = 0;
   logic [31:0] hist[$];
   int          n_fail = 0, samples_checked = 0;
   initial forever #2.5 clk_sys_in = ~clk_sys_in;
   tsc_ctrl #(.CYC_PER_MS(10)) dut (.*, .talk_addr_in(stim[0]), .get_in(stim[1]),
      .exec_char_in(stim[2]), .ext_trig_in(stim[3]), .enter_key_in(stim[4]));
   tsc_conv_model model (.clk_sys_in, .rstn_in, .start_in(conv_start_out),
      .done_out(conv_done_in), .data_out(conv_data_in));
   always @(posedge clk_sys_in) if (conv_done_in === 1'b1) hist.push_back(conv_data_in);
   // ==========================================
   // Tasks and expectations
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1;
      do @(posedge clk_sys_in); while (pready_out !== 1'b1);
      rv = prdata_out;
      rerr = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
   endtask : apb
   task automatic pulse(input int s);
      @(posedge clk_sys_in);
      stim <= 5'h01 << s;
      @(posedge clk_sys_in);
      stim <= 5'h00;
      repeat (12) @(posedge clk_sys_in);
   endtask : pulse
   task automatic wait_full;
      for (int i = 0; i < 2000 && buf_full_out !== 1'b1; i++) @(posedge clk_sys_in);
      chk("full wait", 32'h1, {31'h0, buf_full_out});
   endtask : wait_full
   function automatic logic [31:0] pick(input bit hi);
      pick = hist[0];
      for (int i = 1; i < 3; i++) if (($signed(hist[i]) > $signed(pick)) == hi) pick = hist[i];
   endfunction : pick
   function automatic int stores(input int m);
      return (m == 7) ? 2 : 1;
   endfunction : stores
   task automatic wrap_up;
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_sys_in);
      rstn_in <= 1;
      apb(0, 8'h00, 0);
      chk("ctrl", 32'h0, rv);
      apb(0, 8'h40, 0);
      chk("unmapped", 32'h1, {31'h0, rerr});
      apb(1, 8'h00, 32'h3);
      apb(1, 8'h04, 0);
      apb(1, 8'h08, 32'h3);
      chk("dashes", 32'h1, {31'h0, dashes_out});
      hist.delete();
      pulse(0);
      for (int i = 0; i < 4; i++) pulse(1);
      chk("full", 32'h1, {31'h0, buf_full_out});
      apb(0, 8'h24, 0);
      chk("count", 32'h3, rv);
      apb(1, 8'h00, 32'hb);
      for (int i = 0; i < 4; i++)
      begin
         apb(0, 8'h14, 0);
         chk("recall", hist[i % 3], rv);
      end
      apb(0, 8'h18, 0);
      chk("max", pick(1), rv);
      apb(0, 8'h1c, 0);
      chk("min", pick(0), rv);
      for (int m = 1; m < 8; m += 2)
      begin
         apb(1, 8'h00, m);
         apb(1, 8'h04, 0);
         for (int s = 0; s < 5; s++) pulse(s);
         apb(0, 8'h24, 0);
         chk("pair count", stores(m), rv);
      end
      for (int k = 0; k < 4; k++)
      begin
         apb(1, 8'h00, 32'h4 | ((2 + k / 2) << 4));
         apb(1, 8'h04, ((k / 2) ? 35 : 31) - k % 2);
         apb(1, 8'h08, 32'h2);
         repeat (300) @(posedge clk_sys_in);
         apb(0, 8'h24, 0);
         chk("count idle", 32'h0, rv);
         pulse(2);
         wait_full;
         apb(0, 8'h10, 0);
         chk("short", k % 2, {31'h0, rv[9]});
         apb(0, 8'h24, 0);
         chk("timed count", 32'h2, rv);
      end
      apb(1, 8'h04, 32'h5);
      apb(1, 8'h08, 0);
      pulse(2);
      apb(0, 8'h10, 0);
      chk("conflict", 32'h1, {31'h0, rv[8]});
      chk("blank", 32'h0, {31'h0, blank_out});
      apb(1, 8'h00, 32'h4);
      apb(1, 8'h08, 32'h4);
      pulse(2);
      chk("blank run", 32'h1, {31'h0, blank_out});
      apb(0, 8'h14, 0);
      chk("latest", 32'h1, {31'h0, (rv === hist[$]) || (rv === hist[$-1])});
      apb(1, 8'h0c, 32'h1);
      repeat (200) @(posedge clk_sys_in);
      apb(0, 8'h24, 0);
      chk("stopped", 32'h0, rv);
      pulse(2);
      wait_full;
      apb(0, 8'h24, 0);
      chk("hs count", 32'h4, rv);
      for (int m = 0; m < 8; m++)
      begin
         apb(1, 8'h00, m);
         apb(1, 8'h04, 0);
         pulse(m / 2);
         apb(0, 8'h10, 0);
         chk("option", {31'h0, ~m[0]}, {31'h0, rv[7]});
      end
      apb(1, 8'h0c, 32'h2);
      apb(0, 8'h00, 0);
      chk("ctrl clear", 32'h0, rv);
      wrap_up;
   end
   // Hang guard
   initial
   begin
      repeat (60000) @(posedge clk_sys_in);
      n_fail++;
      wrap_up;
   end
endmodule : testbench
bind tsc_ctrl tsc_ctrl_chk chk_i (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .conv_start_out, .conv_done_in,
   .dashes_out, .buf_full_out);

/* File: verification/tsc_conv_model.sv */
// Behavioural converter answering each start with one reading
`timescale 1ns/1ps
module tsc_conv_model (
   // Clock and reset
   input wire logic   clk_sys_in,
   input wire logic   rstn_in,
   // Converter handshake
   input wire logic   start_in,
   output logic        done_out,
   output logic [31:0] data_out
);
   int seed = 99;
   // ==========================================
   // Random latency, data only valid with done
   initial
   begin
      done_out = 1'b0;
      data_out = 32'h0;
      forever
      begin
         @(posedge clk_sys_in);
         if (start_in === 1'b1 && rstn_in)
         begin
            repeat (1 + {$random(seed)} % 6) @(posedge clk_sys_in);
            done_out <= 1'b1;
            data_out <= $random(seed);
            @(posedge clk_sys_in);
            done_out <= 1'b0;
            data_out <= ~data_out; // Stale value scrambled
         end
      end
   end
endmodule : tsc_conv_model

/* File: verification/tsc_ctrl_assertions.sv */
// Port checker of the trigger and store control block
`timescale 1ns/1ps
module tsc_ctrl_chk (
   // Clock, reset and bus
   input wire logic        clk_sys_in,
   input wire logic        rstn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Converter and display
   input wire logic        conv_start_out,
   input wire logic        conv_done_in,
   input wire logic        dashes_out,
   input wire logic        buf_full_out
);
   // ==========================================
   // Helpers
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   sequence s_wr;
      psel_in && penable_in && pwrite_in;
   endsequence
   sequence s_one_start;
      conv_start_out ##1 !conv_start_out;
   endsequence
   // ==========================================
   // Assertions
   a_ready_high: assert property (pready_out) else $error("ready low");
   a_err_phase: assert property (pslverr_out |-> psel_in && penable_in)
      else $error("error outside access");
   a_err_map: assert property (psel_in && penable_in && paddr_in[1:0] == 2'h0
      |-> pslverr_out == (paddr_in > 8'h24)) else $error("error map wrong");
   a_rd_hold: assert property (!$stable(prdata_out) |-> $past(psel_in && !penable_in))
      else $error("read data moved");
   a_start_pulse: assert property (conv_start_out |-> s_one_start)
      else $error("start not a pulse");
   a_dash_cause: assert property ($rose(dashes_out) |->
      $past(psel_in && penable_in && pwrite_in && paddr_in inside {8'h04, 8'h08}))
      else $error("dashes without arm");
   a_full_cause: assert property ($rose(buf_full_out) |->
      $past(conv_done_in) || $past(conv_done_in, 2)) else $error("full without store");
   a_full_drop: assert property ($fell(buf_full_out) |->
      $past(psel_in && penable_in && pwrite_in)) else $error("full dropped alone");
   a_arm_dash: assert property ((s_wr ##0 (paddr_in inside {8'h04, 8'h08})) |=> dashes_out)
      else $error("dashes not set on arm");
endmodule : tsc_ctrl_chk

/* File: verilog/tsc_ctrl.sv */
// Trigger mode and reading-store control with APB register access
//
// How it works
// - eight modes, even continuous, odd one-shot
// - continuous runs on; one-shot needs stimuli
// - modes 0,1 trigger on talk address
// - modes 2,3 trigger on GET
// - modes 4,5 trigger on execute character
// - modes 6,7 external pulse or enter key
// - source 0 converter, 1 buffer
// - converter source refreshes at conversion rate
// - buffer recall from first location, wraps
// - one-shot storage stores one per trigger
// - one-shot storage with continuous mode errors
// - interval in ms; timed needs continuous
// - timed storage starts at trigger only
// - enter stores one or starts series
// - size 0 wraps at 500, never stops
// - size n stops at n, buffer full
// - dashes after interval/size until trigger
// - function select disables, trigger resumes
// - 1-14 ms high speed, blank, conflict
// - unmeetable interval flags short, stores fastest
// - rates 2,3 minimum 31, 35 ms
// - recall during/after; max, min, sum kept
// - high speed needs valid rate, size, range
`timescale 1ns/1ps
module tsc_ctrl #(
   parameter int DW         = 32,
   parameter int DEPTH      = tsc_pkg::STORE_DEPTH,
   parameter int CYC_PER_MS = tsc_pkg::CYC_PER_MS
) (
   // Clock and reset
   input  wire logic          clk_sys_in,
   input  wire logic          rstn_in,
   // APB slave
   input  wire logic          psel_in,
   input  wire logic          penable_in,
   input  wire logic          pwrite_in,
   input  wire logic [7:0]    paddr_in,
   input  wire logic [31:0]   pwdata_in,
   output logic      [31:0]   prdata_out,
   output logic               pready_out,
   output logic               pslverr_out,
   // Trigger stimuli, one-cycle pulses
   input  wire logic          talk_addr_in,
   input  wire logic          get_in,
   input  wire logic          exec_char_in,
   input  wire logic          ext_trig_in,
   input  wire logic          enter_key_in,
   // Converter
   output logic               conv_start_out,
   input  wire logic          conv_done_in,
   input  wire logic [DW-1:0] conv_data_in,
   // Display and status
   output logic               dashes_out,
   output logic               blank_out,
   output logic               buf_full_out
);

   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // State types
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARM  = 4'h2,
      ST_RUN  = 4'h4,
      ST_FULL = 4'h8
   } tsc_st_t;

   typedef struct packed {
      tsc_st_t       st;
      logic [2:0]    mode;
      logic          src;
      logic [1:0]    rate;
      logic          auto_rng;
      logic [19:0]   interval;
      logic [8:0]    size;
      logic          run;
      logic          pend;
      logic          dashes;
      logic          hs;
      logic          fast;
      logic          err_opt;
      logic          err_conf;
      logic          err_short;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [8:0]    count;
      logic          wrapped;
      logic [DW-1:0] latest;
      logic [DW-1:0] max;
      logic [DW-1:0] min;
      logic [31:0]   sum;
      logic [31:0]   rdata;
      logic          start;
   } tsc_state_t;

   tsc_state_t s_q;
   tsc_state_t s_d;

   logic          stim;
   logic          one_shot;
   logic          wr_acc;
   logic          rd_acc;
   logic          mapped;
   logic          due;
   logic          store;
   logic          tmr_restart;
   logic          hs_ok;
   logic          slow_ok;
   logic [DW-1:0] buf_rdata;
   logic [8:0]    avail;

   // ==========================================================
   // Stimulus selection by mode pair
   always_comb
   begin
      case (s_q.mode[2:1])
         tsc_pkg::PAIR_TALK: stim = talk_addr_in;
         tsc_pkg::PAIR_GET:  stim = get_in;
         tsc_pkg::PAIR_EXEC: stim = exec_char_in;
         default:            stim = ext_trig_in | enter_key_in;
      endcase
   end

   assign one_shot = s_q.mode[0];

   // Bus access decode
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign rd_acc = psel_in && penable_in && !pwrite_in;

   always_comb
   begin
      if (paddr_in == tsc_pkg::OFS_CTRL || paddr_in == tsc_pkg::OFS_INTERVAL)
      begin
         mapped = 1'b1;
      end
      else if (paddr_in == tsc_pkg::OFS_SIZE || paddr_in == tsc_pkg::OFS_CMD)
      begin
         mapped = 1'b1;
      end
      else if (paddr_in == tsc_pkg::OFS_STATUS || paddr_in == tsc_pkg::OFS_DATA)
      begin
         mapped = 1'b1;
      end
      else if (paddr_in == tsc_pkg::OFS_MAX || paddr_in == tsc_pkg::OFS_MIN)
      begin
         mapped = 1'b1;
      end
      else if (paddr_in == tsc_pkg::OFS_SUM || paddr_in == tsc_pkg::OFS_COUNT)
      begin
         mapped = 1'b1;
      end
      else
      begin
         mapped = 1'b0;
      end
   end

   // High speed and slow-rate checks
   always_comb
   begin
      if (s_q.interval <= tsc_pkg::HS_S0_ONLY_MS)
      begin
         hs_ok = (s_q.rate == tsc_pkg::RATE_RST);
      end
      else
      begin
         hs_ok = (s_q.rate == tsc_pkg::RATE_RST) || (s_q.rate == tsc_pkg::RATE_S1);
      end
      hs_ok = hs_ok && !s_q.auto_rng && (s_q.size != 9'h0);
      if (s_q.rate == tsc_pkg::RATE_S2)
      begin
         slow_ok = (s_q.interval >= tsc_pkg::MIN_MS_S2);
      end
      else if (s_q.rate == tsc_pkg::RATE_S3)
      begin
         slow_ok = (s_q.interval >= tsc_pkg::MIN_MS_S3);
      end
      else
      begin
         slow_ok = 1'b1;
      end
   end

   // Number of readings available for recall
   assign avail = s_q.wrapped ? 9'(DEPTH) : s_q.count;

   // A reading is stored on a conversion result in the running state
   always_comb
   begin
      store = 1'b0;
      if (s_q.st == ST_RUN && conv_done_in)
      begin
         if (s_q.interval == tsc_pkg::INTERVAL_RST)
         begin
            store = s_q.pend;
         end
         else
         begin
            store = due || s_q.fast;
         end
      end
   end

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      s_d         = s_q;
      s_d.start   = 1'b0;
      tmr_restart = 1'b0;

      // Conversion control
      if (one_shot)
      begin
         s_d.run = 1'b0;
         if (stim)
         begin
            s_d.start = 1'b1;
         end
      end
      else if (!s_q.run && stim)
      begin
         s_d.run   = 1'b1;
         s_d.start = 1'b1;
      end
      else if (s_q.run && conv_done_in)
      begin
         s_d.start = 1'b1;
      end
      if (conv_done_in)
      begin
         s_d.latest = conv_data_in;
      end

      // Storage sequencing
      case (s_q.st)
         ST_ARM:
         begin
            if (stim)
            begin
               s_d.dashes = 1'b0;
               if (s_q.interval == tsc_pkg::INTERVAL_RST && !one_shot)
               begin
                  s_d.err_opt = 1'b1;
               end
               else if (s_q.interval != tsc_pkg::INTERVAL_RST && one_shot)
               begin
                  s_d.err_opt = 1'b1;
               end
               else if (s_q.interval != tsc_pkg::INTERVAL_RST && s_q.hs && !hs_ok)
               begin
                  s_d.err_conf = 1'b1;
               end
               else
               begin
                  s_d.st        = ST_RUN;
                  s_d.pend      = (s_q.interval == tsc_pkg::INTERVAL_RST);
                  s_d.fast      = !slow_ok;
                  s_d.err_short = s_q.err_short || !slow_ok;
                  tmr_restart   = 1'b1;
               end
            end
         end
         ST_RUN:
         begin
            if (s_q.interval == tsc_pkg::INTERVAL_RST && stim && !s_q.pend)
            begin
               s_d.pend = 1'b1;
            end
            if (store)
            begin
               s_d.pend    = 1'b0;
               tmr_restart = 1'b1;
               if (s_q.wr_ptr == AW'(DEPTH - 1))
               begin
                  s_d.wr_ptr  = '0;
                  s_d.wrapped = 1'b1;
               end
               else
               begin
                  s_d.wr_ptr = s_q.wr_ptr + AW'(1);
               end
               if (s_q.count != 9'(DEPTH))
               begin
                  s_d.count = s_q.count + 9'h1;
               end
               if (s_q.size != tsc_pkg::SIZE_RST && s_q.count + 9'h1 == s_q.size)
               begin
                  s_d.st = ST_FULL;
               end
               if (s_q.count == 9'h0 || $signed(conv_data_in) > $signed(s_q.max))
               begin
                  s_d.max = conv_data_in;
               end
               if (s_q.count == 9'h0 || $signed(conv_data_in) < $signed(s_q.min))
               begin
                  s_d.min = conv_data_in;
               end
               s_d.sum = s_q.sum + 32'(conv_data_in);
            end
         end
         default:
         begin
         end
      endcase

      // Register writes
      if (wr_acc)
      begin
         if (paddr_in == tsc_pkg::OFS_CTRL)
         begin
            s_d.mode     = pwdata_in[tsc_pkg::CTRL_MODE_LSB +: 3];
            s_d.src      = pwdata_in[tsc_pkg::CTRL_SRC_BIT];
            s_d.rate     = pwdata_in[tsc_pkg::CTRL_RATE_LSB +: 2];
            s_d.auto_rng = pwdata_in[tsc_pkg::CTRL_AUTO_BIT];
            if (pwdata_in[tsc_pkg::CTRL_SRC_BIT] == tsc_pkg::SRC_BUF)
            begin
               s_d.rd_ptr = '0;
            end
         end
         else if (paddr_in == tsc_pkg::OFS_INTERVAL || paddr_in == tsc_pkg::OFS_SIZE)
         begin
            if (paddr_in == tsc_pkg::OFS_INTERVAL)
            begin
               s_d.interval = (pwdata_in[19:0] > tsc_pkg::INTERVAL_MAX_MS) ?
                              tsc_pkg::INTERVAL_MAX_MS : pwdata_in[19:0];
            end
            else
            begin
               s_d.size = (pwdata_in[8:0] > 9'(DEPTH)) ? 9'(DEPTH) : pwdata_in[8:0];
            end
            s_d.st        = ST_ARM;
            s_d.dashes    = 1'b1;
            s_d.pend      = 1'b0;
            s_d.err_opt   = 1'b0;
            s_d.err_conf  = 1'b0;
            s_d.err_short = 1'b0;
            s_d.wr_ptr    = '0;
            s_d.count     = 9'h0;
            s_d.wrapped   = 1'b0;
            s_d.sum       = 32'h0;
         end
         else if (paddr_in == tsc_pkg::OFS_CMD)
         begin
            if (pwdata_in[tsc_pkg::CMD_FUNC_BIT] && s_q.st != ST_IDLE)
            begin
               s_d.st   = ST_ARM;
               s_d.pend = 1'b0;
            end
         end
      end
      s_d.hs = (s_d.interval != tsc_pkg::INTERVAL_RST) && (s_d.interval <= tsc_pkg::HS_MAX_MS);

      // Buffer recall advances on each data read
      if (rd_acc && paddr_in == tsc_pkg::OFS_DATA && s_q.src == tsc_pkg::SRC_BUF)
      begin
         if (9'(s_q.rd_ptr) + 9'h1 >= avail)
         begin
            s_d.rd_ptr = '0;
         end
         else
         begin
            s_d.rd_ptr = s_q.rd_ptr + AW'(1);
         end
      end

      // Read data register
      if (psel_in && !penable_in && !pwrite_in)
      begin
         s_d.rdata = 32'h0;
         if (paddr_in == tsc_pkg::OFS_CTRL)
         begin
            s_d.rdata[6:0] = {s_q.auto_rng, s_q.rate, s_q.src, s_q.mode};
         end
         else if (paddr_in == tsc_pkg::OFS_INTERVAL)
         begin
            s_d.rdata[19:0] = s_q.interval;
         end
         else if (paddr_in == tsc_pkg::OFS_SIZE)
         begin
            s_d.rdata[8:0] = s_q.size;
         end
         else if (paddr_in == tsc_pkg::OFS_STATUS)
         begin
            s_d.rdata[11:0] = {s_q.run, s_q.hs, s_q.err_short, s_q.err_conf,
                               s_q.err_opt, s_q.dashes, s_q.wrapped, s_q.fast,
                               s_q.st};
         end
         else if (paddr_in == tsc_pkg::OFS_DATA)
         begin
            s_d.rdata = 32'((s_q.src == tsc_pkg::SRC_BUF) ? buf_rdata : s_q.latest);
         end
         else if (paddr_in == tsc_pkg::OFS_MAX)
         begin
            s_d.rdata = 32'(s_q.max);
         end
         else if (paddr_in == tsc_pkg::OFS_MIN)
         begin
            s_d.rdata = 32'(s_q.min);
         end
         else if (paddr_in == tsc_pkg::OFS_SUM)
         begin
            s_d.rdata = s_q.sum;
         end
         else if (paddr_in == tsc_pkg::OFS_COUNT)
         begin
            s_d.rdata[8:0] = s_q.count;
         end
      end

      // Device clear returns every setting to its default
      if (wr_acc && paddr_in == tsc_pkg::OFS_CMD && pwdata_in[tsc_pkg::CMD_CLR_BIT])
      begin
         s_d       = '0;
         s_d.st    = ST_IDLE;
         s_d.rdata = s_q.rdata;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.mode <= tsc_pkg::MODE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Reading buffer
   tsc_rdg_mem #(
      .DW    (DW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk_sys_in  (clk_sys_in),
      .wr_en_in    (store),
      .wr_addr_in  (s_q.wr_ptr),
      .wr_data_in  (conv_data_in),
      .rd_addr_in  (s_q.rd_ptr),
      .rd_data_out (buf_rdata)
   );

   // Storage interval timer
   tsc_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tmr (
      .clk_sys_in  (clk_sys_in),
      .rstn_in     (rstn_in),
      .restart_in  (tmr_restart),
      .interval_in (s_q.interval),
      .due_out     (due)
   );

   // ==========================================================
   // Outputs
   assign prdata_out     = s_q.rdata;
   assign pready_out     = 1'b1;
   assign pslverr_out    = psel_in && penable_in && !mapped;
   assign conv_start_out = s_q.start;
   assign dashes_out     = s_q.dashes;
   assign blank_out      = s_q.hs && (s_q.st == ST_RUN);
   assign buf_full_out   = (s_q.st == ST_FULL);

endmodule : tsc_ctrl

/* File: verilog/tsc_ms_timer.sv */
// Millisecond tick and storage interval timer
`timescale 1ns/1ps
module tsc_ms_timer #(
   parameter int CYC_PER_MS = tsc_pkg::CYC_PER_MS
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // Control
   input  wire logic        restart_in,
   input  wire logic [19:0] interval_in,
   // Status
   output logic             due_out
);

   typedef struct packed {
      logic [31:0] tick;
      logic [19:0] ms;
   } tsc_tmr_t;

   tsc_tmr_t s_q;
   tsc_tmr_t s_d;

   // ==========================================================
   // Tick divider and elapsed millisecond count
   always_comb
   begin
      s_d = s_q;
      if (restart_in)
      begin
         s_d.tick = 32'h0;
         s_d.ms   = 20'h0;
      end
      else if (s_q.tick == 32'(CYC_PER_MS - 1))
      begin
         s_d.tick = 32'h0;
         if (s_q.ms != tsc_pkg::INTERVAL_MAX_MS)
         begin
            s_d.ms = s_q.ms + 20'h1;
         end
      end
      else
      begin
         s_d.tick = s_q.tick + 32'h1;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Interval reached since the last restart
   assign due_out = (s_q.ms >= interval_in);

endmodule : tsc_ms_timer

/* File: verilog/tsc_pkg.sv */
// Constants shared by the trigger and reading-store control block
package tsc_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_INTERVAL = 8'h04;
   localparam logic [7:0] OFS_SIZE     = 8'h08;
   localparam logic [7:0] OFS_CMD      = 8'h0c;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_DATA     = 8'h14;
   localparam logic [7:0] OFS_MAX      = 8'h18;
   localparam logic [7:0] OFS_MIN      = 8'h1c;
   localparam logic [7:0] OFS_SUM      = 8'h20;
   localparam logic [7:0] OFS_COUNT    = 8'h24;

   // ==========================================================
   // Field positions
   localparam int CTRL_MODE_LSB = 0;   // Trigger mode code, 3 bits
   localparam int CTRL_SRC_BIT  = 3;   // Bus output source
   localparam int CTRL_RATE_LSB = 4;   // Rate setting, 2 bits
   localparam int CTRL_AUTO_BIT = 6;   // Autorange in use
   localparam int CMD_FUNC_BIT  = 0;   // Function select: disable storage
   localparam int CMD_CLR_BIT   = 1;   // Device clear

   // ==========================================================
   // Codes and reset values
   localparam logic [2:0]  MODE_RST    = 3'h0;
   localparam logic [1:0]  PAIR_TALK   = 2'h0;
   localparam logic [1:0]  PAIR_GET    = 2'h1;
   localparam logic [1:0]  PAIR_EXEC   = 2'h2;
   localparam logic [1:0]  PAIR_EXT    = 2'h3;
   localparam logic        SRC_CONV    = 1'b0;
   localparam logic        SRC_BUF     = 1'b1;
   localparam logic [1:0]  RATE_RST    = 2'h0;
   localparam logic [1:0]  RATE_S1     = 2'h1;
   localparam logic [1:0]  RATE_S2     = 2'h2;
   localparam logic [1:0]  RATE_S3     = 2'h3;
   localparam logic [19:0] INTERVAL_RST = 20'h00000;
   localparam logic [8:0]  SIZE_RST    = 9'h000;

   // ==========================================================
   // Storage limits, in milliseconds and readings
   localparam logic [19:0] INTERVAL_MAX_MS = 20'hf423f;  // 999999
   localparam logic [19:0] HS_MAX_MS       = 20'h0000e;  // 14
   localparam logic [19:0] HS_S0_ONLY_MS   = 20'h00002;  // 2
   localparam logic [19:0] MIN_MS_S2       = 20'h0001f;  // 31
   localparam logic [19:0] MIN_MS_S3       = 20'h00023;  // 35
   localparam int          STORE_DEPTH     = 500;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MS_PS         = 1000000000;
   localparam int CYC_PER_MS    = MS_PS / CLK_PERIOD_PS;

endpackage : tsc_pkg

/* File: verilog/tsc_rdg_mem.sv */
// Reading buffer: one write port, one registered read port
`timescale 1ns/1ps
module tsc_rdg_mem #(
   parameter int DW    = 32,
   parameter int DEPTH = 500,
   parameter int AW    = 9
) (
   // Clock
   input  wire logic          clk_sys_in,
   // Write port
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   // Read port
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);

   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rd_data_q;

   // ==========================================================
   // Storage array and read register
   always_ff @(posedge clk_sys_in)
   begin
      if (wr_en_in)
      begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_q <= mem_q[rd_addr_in];
   end

   assign rd_data_out = rd_data_q;

endmodule : tsc_rdg_mem
